// ### bench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // From bench and unit
  input  wire logic        i_go_halt,
  input  wire logic        i_cpu_clk_en,
  input  wire logic        i_ctx_save,
  input  wire logic        i_branch,
  input  wire logic        i_pm_rd,
  input  wire logic [15:0] i_pm_addr,
  // To unit
  output logic             o_halt,
  output logic             o_core_ready,
  output logic [7:0]       o_pm_data
);
  logic busy_reg;
  assign o_core_ready = i_cpu_clk_en & ~busy_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg  <= 1'b0;
      o_halt    <= 1'b0;
      o_pm_data <= 8'h00;
    end else begin
      o_halt    <= i_go_halt & i_cpu_clk_en;
      busy_reg  <= (busy_reg | i_ctx_save) & ~i_branch;
      o_pm_data <= i_pm_rd ? (8'h90 ^ i_pm_addr[7:0]) : ~o_pm_data;
    end
  end
endmodule : core_model
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_sys_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        i_port3_line1, i_port3_line2, i_port3_line3, i_comparator_one_in;
  logic        i_comparator_two_in, i_low_voltage_detect, i_short_tc, i_long_tc, go_halt;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, rnd;
  wire logic   o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_short_enable;
  wire logic   o_long_enable, o_cpu_clk_en, o_ctx_save, o_pm_rd, o_branch, o_int_out;
  wire logic   i_halt, i_core_ready;
  wire logic [1:0]  o_bresp, o_rresp;
  wire logic [31:0] o_rdata;
  wire logic [15:0] o_pm_addr, o_isr_addr;
  wire logic [7:0]  i_pm_data;
  logic [33:0] rdq[$];
  logic [15:0] brq[$];
  int          err_total, tests_run, cyc_cnt;

  vectored_interrupt_unit i_vectored_interrupt_unit (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
    .i_wstrb(4'hf), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .i_port3_line1(i_port3_line1), .i_port3_line2(i_port3_line2),
    .i_port3_line3(i_port3_line3), .i_comparator_one_in(i_comparator_one_in),
    .i_comparator_two_in(i_comparator_two_in), .i_low_voltage_detect(i_low_voltage_detect),
    .i_short_tc(i_short_tc), .i_long_tc(i_long_tc), .o_short_enable(o_short_enable),
    .o_long_enable(o_long_enable), .i_halt(i_halt), .i_core_ready(i_core_ready),
    .o_cpu_clk_en(o_cpu_clk_en), .o_ctx_save(o_ctx_save), .o_pm_rd(o_pm_rd),
    .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data), .o_branch(o_branch),
    .o_isr_addr(o_isr_addr), .o_int_out(o_int_out));

  core_model i_core_model (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_go_halt(go_halt),
    .i_cpu_clk_en(o_cpu_clk_en), .i_ctx_save(o_ctx_save), .i_branch(o_branch),
    .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr), .o_halt(i_halt),
    .o_core_ready(i_core_ready), .o_pm_data(i_pm_data));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [15:0] vec(input int n);
    return {8'h90 ^ 8'(2 * n), 8'h90 ^ 8'(2 * n + 1)};
  endfunction : vec

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    i_awaddr  <= {idx, 2'b00};
    i_wdata   <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    do @(posedge i_sys_clk); while (o_awready !== 1'b1);
    chk("wready", 34'(o_wready), 34'h1);
    i_awvalid <= 1'b0;
    i_wvalid  <= 1'b0;
    i_bready  <= 1'b1;
    do @(posedge i_sys_clk); while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    chk("bresp", 34'(o_bresp), 34'(idx[9:3] == 7'h1f ? 2'h0 : 2'h2));
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    @(posedge i_sys_clk);
    rdq.push_back({idx[9:3] == 7'h1f ? 2'h0 : 2'h2, 24'h0, e});
    i_araddr  <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    do @(posedge i_sys_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_sys_clk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
  endtask : rd

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // Scoreboard takes the oldest note per result
  always @(posedge i_sys_clk) begin
    cyc_cnt++;
    if (o_rvalid === 1'b1 && i_rready) chk("rdata", {o_rresp, o_rdata}, rdq.pop_front());
    if (o_branch === 1'b1) chk("isr", 34'(o_isr_addr), 34'(brq.pop_front()));
    // Context save must have held the core until the branch
    if (o_branch === 1'b1) chk("core held", 34'(i_core_ready), 34'h0);
    if (cyc_cnt == 8000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, go_halt} = '0;
    {i_port3_line1, i_port3_line2, i_port3_line3, i_comparator_one_in} = '0;
    {i_comparator_two_in, i_low_voltage_detect, i_short_tc, i_long_tc} = '0;
    {i_awaddr, i_araddr, i_wdata} = '0;
    rnd = 32'd54756;
    cyc(4);
    i_rst_n <= 1'b1;
    cyc(1);
    // reset values and one unmapped place
    for (int k = 7; k < 16; k++) rd(10'h0f0 + 10'(k), 8'h00);
    for (int k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      wr(vint_pkg::IDX_REQ, rnd[7:0]);
      rd(vint_pkg::IDX_REQ, rnd[7:0]);
    end
    for (int c = 0; c < 4; c++) begin
      for (int v = 1; v >= 0; v--) begin
        wr(vint_pkg::IDX_REQ, {2'(c), 6'h00});
        {i_port3_line1, i_port3_line2, i_comparator_one_in, i_comparator_two_in} <= {4{v[0]}};
        cyc(6);
        rd(vint_pkg::IDX_REQ, {2'(c), 3'h0, v ? c[1] : c != 2, 1'b0, v ? c[0] : c != 1});
      end
    end
    wr(vint_pkg::IDX_REQ, 8'h00);
    i_port3_line3        <= 1'b1;
    i_low_voltage_detect <= 1'b1;
    cyc(6);
    rd(vint_pkg::IDX_REQ, 8'h20);
    i_port3_line3 <= 1'b0;
    cyc(6);
    rd(vint_pkg::IDX_REQ, 8'h22);
    wr(vint_pkg::IDX_REQ, 8'h00);
    wr(vint_pkg::IDX_LONG, 8'h02);
    {i_short_tc, i_long_tc} <= 2'b11;
    cyc(1);
    {i_short_tc, i_long_tc} <= 2'b00;
    cyc(2);
    rd(vint_pkg::IDX_REQ, 8'h08);
    rd(vint_pkg::IDX_LONG, 8'h22);
    rd(vint_pkg::IDX_SHORT, 8'h20);
    wr(vint_pkg::IDX_MODE, 8'h01);
    wr(vint_pkg::IDX_SHORT, 8'h82);
    i_short_tc <= 1'b1;
    cyc(1);
    i_short_tc <= 1'b0;
    cyc(2);
    chk("timer enables", 34'({o_short_enable, o_long_enable}), 34'h1);
    wr(vint_pkg::IDX_PRIO, 8'h04);
    brq.push_back(vec(4));
    wr(vint_pkg::IDX_MASK, 8'hbf);
    while (brq.size() != 0) cyc(1);
    rd(vint_pkg::IDX_MASK, 8'h3f);
    rd(vint_pkg::IDX_REQ, 8'h08);
    brq.push_back(vec(3));
    wr(vint_pkg::IDX_MASK, 8'hbf);
    while (brq.size() != 0) cyc(1);
    wr(vint_pkg::IDX_MASK, 8'hbf);
    i_port3_line1 <= 1'b1;
    i_low_voltage_detect <= 1'b0;
    cyc(6);
    go_halt <= 1'b1;
    cyc(1);
    go_halt <= 1'b0;
    // low-voltage rise in halt must not win
    i_low_voltage_detect <= 1'b1;
    wr(vint_pkg::IDX_EMASK, 8'h02);
    chk("halted, line masked", 34'({o_cpu_clk_en, o_int_out}), 34'h0);
    brq.push_back(vec(2));
    i_port3_line1 <= 1'b0;
    while (brq.size() != 0) cyc(1);
    cyc(2);
    chk("woken, line up", 34'({o_cpu_clk_en, o_int_out}), 34'h3);
    rd(vint_pkg::IDX_STAT, 8'h0f);
    rd(vint_pkg::IDX_STAT, 8'h00);
    chk("line cleared", 34'(o_int_out), 34'h0);
    cyc(2);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

// ### logic/int_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface int_arb_if #(parameter int NUM = vint_pkg::NUM_CHAN);
  logic [NUM-1:0] pending;
  logic [2:0]     first;
  logic           hit;
  logic [2:0]     chan;
  modport requester (output pending, output first, input hit, input chan);
  modport arbiter   (input pending, input first, output hit, output chan);
endinterface : int_arb_if
`default_nettype wire

// ### logic/pin_edge_sense.sv
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sense #(
  parameter int STAGES = vint_pkg::SYNC_STAGES
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_clk_en,
  // Pin and edge choice
  input  wire logic i_pin,
  input  wire logic i_rise_en,
  input  wire logic i_fall_en,
  // Detected edge
  output logic      o_event
);
  if (STAGES < 2) begin : g_bad_stages
    $error("pin_edge_sense needs at least two stages");
  end

  logic [STAGES-1:0] sync_reg;
  logic [STAGES:0]   fill_reg;
  logic              last_reg;

  // Fill guard stops a false edge while the chain loads after reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_reg <= '0;
      fill_reg <= '0;
      last_reg <= 1'b0;
    end else if (i_clk_en) begin
      sync_reg <= {sync_reg[STAGES-2:0], i_pin};
      fill_reg <= {fill_reg[STAGES-1:0], 1'b1};
      last_reg <= sync_reg[STAGES-1];
    end
  end

  assign o_event = fill_reg[STAGES] &
                   ((sync_reg[STAGES-1] & ~last_reg & i_rise_en) |
                    (~sync_reg[STAGES-1] & last_reg & i_fall_en));
endmodule : pin_edge_sense
`default_nettype wire

// ### logic/priority_pick.sv
`timescale 1ns/1ps
`default_nettype none
module priority_pick #(
  parameter int NUM = vint_pkg::NUM_CHAN
) (
  // Pending set in, winner out
  int_arb_if.arbiter arb
);
  if (NUM < 1 || NUM > 8) begin : g_bad_num
    $error("priority_pick serves one to eight channels");
  end

  // Rotating order: the programmed channel first, then upward with wrap
  function automatic logic [3:0] pick(input logic [NUM-1:0] pend, input logic [2:0] first);
    int base;
    int c;
    logic [3:0] res;
    base = (int'(first) < NUM) ? int'(first) : 0;
    res = 4'h0;
    for (int k = NUM - 1; k >= 0; k--) begin
      c = (base + k) % NUM;
      if (pend[c]) begin
        res = {1'b1, 3'(c)};
      end
    end
    return res;
  endfunction : pick

  assign {arb.hit, arb.chan} = pick(arb.pending, arb.first);
endmodule : priority_pick
`default_nettype wire

// ### logic/vectored_interrupt_unit.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - six sources: three pins, two timers, low-voltage
// - channel n vector at bytes 2n, 2n+1
// - channel one: falling edge only
// - global and per-channel enable mask
// - programmable priority picks among pending requests
// - grant disables interrupts, saves context, branches
// - service address from two program-memory bytes
// - masked requests still latch for polling
// - comparator one to channel two, two to zero
// - request bits 7:6 select channel two/zero edges
// - channels zero-four and timers stay alive in halt
// - halt ends only by serviced request
// - alternating mode swaps timer enables, sets timeouts
// - short timer request needs its enable bit 1
// - long timer request needs bit 1, sets 5
module vectored_interrupt_unit (
  // Clock, reset, freeze
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  // AXI4-Lite write
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Pins and analog events
  input  wire logic        i_port3_line1,
  input  wire logic        i_port3_line2,
  input  wire logic        i_port3_line3,
  input  wire logic        i_comparator_one_in,
  input  wire logic        i_comparator_two_in,
  input  wire logic        i_low_voltage_detect,
  // Timers
  input  wire logic        i_short_tc,
  input  wire logic        i_long_tc,
  output logic             o_short_enable,
  output logic             o_long_enable,
  // Processor core
  input  wire logic        i_halt,
  input  wire logic        i_core_ready,
  output logic             o_cpu_clk_en,
  output logic             o_ctx_save,
  output logic             o_pm_rd,
  output logic [15:0]      o_pm_addr,
  input  wire logic [7:0]  i_pm_data,
  output logic             o_branch,
  output logic [15:0]      o_isr_addr,
  // Interrupt to system
  output logic             o_int_out
);
  logic [7:0]  req_reg, req_next, mask_reg, mask_next, prio_reg, mode_reg;
  logic [7:0]  stat_reg, stat_next, stat_set, emask_reg;
  logic [7:0]  short_reg, short_next, long_reg, long_next, hi_reg, rdata_reg;
  logic [2:0]  chan_reg;
  logic        halt_reg, halt_next, grant, alt;
  logic [5:0]  src_pin, rise_en, fall_en, edge_ev, ev, clr_vec;
  logic        wr_ready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic        wr_fire, wr_byte, rd_fire;
  logic        wr_req, wr_mask, wr_prio, wr_mode, wr_emask, wr_short, wr_long, rd_stat;
  logic [9:0]  wr_idx, rd_idx;
  logic [7:0]  rd_val;
  logic        ctx_save_reg, pm_rd_reg, branch_reg, cpu_clk_en_reg, int_out_reg;
  logic [15:0] pm_addr_reg, isr_addr_reg;
  vint_pkg::vect_state_t state_reg;

  function automatic logic reg_known(input logic [9:0] idx);
    return idx >= vint_pkg::IDX_MODE && idx <= vint_pkg::IDX_LONG;
  endfunction : reg_known

  function automatic logic [15:0] vec_addr(input logic [2:0] chan);
    return {12'h000, chan, 1'b0};
  endfunction : vec_addr

  // Edge choice for channels two and zero
  // edge select decode
  assign rise_en = {1'b1, req_reg[vint_pkg::EDGE_CHAN0], req_reg[vint_pkg::EDGE_CHAN2],
                    1'b0, req_reg[vint_pkg::EDGE_CHAN0], req_reg[vint_pkg::EDGE_CHAN2]};
  assign fall_en = {1'b0,
                    ~req_reg[vint_pkg::EDGE_CHAN0] | req_reg[vint_pkg::EDGE_CHAN2],
                    ~req_reg[vint_pkg::EDGE_CHAN2] | req_reg[vint_pkg::EDGE_CHAN0],
                    1'b1,
                    ~req_reg[vint_pkg::EDGE_CHAN0] | req_reg[vint_pkg::EDGE_CHAN2],
                    ~req_reg[vint_pkg::EDGE_CHAN2] | req_reg[vint_pkg::EDGE_CHAN0]};
  assign src_pin = {i_low_voltage_detect, i_comparator_two_in, i_comparator_one_in,
                    i_port3_line3, i_port3_line2, i_port3_line1};

  for (genvar g = 0; g < vint_pkg::NUM_CHAN; g++) begin : g_edge
    pin_edge_sense u_edge (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_clk_en  (i_clk_en),
      .i_pin     (src_pin[g]),
      .i_rise_en (rise_en[g]),
      .i_fall_en (fall_en[g]),
      .o_event   (edge_ev[g])
    );
  end

  assign ev[vint_pkg::CH_ZERO] = edge_ev[vint_pkg::SRC_LINE2] | edge_ev[vint_pkg::SRC_CMP2];
  assign ev[vint_pkg::CH_ONE]  = edge_ev[vint_pkg::SRC_LINE3];
  assign ev[vint_pkg::CH_TWO]  = edge_ev[vint_pkg::SRC_LINE1] | edge_ev[vint_pkg::SRC_CMP1];
  assign ev[vint_pkg::CH_LONG] = i_long_tc & long_reg[vint_pkg::TMR_INTEN];
  assign ev[vint_pkg::CH_SHORT] = i_short_tc & short_reg[vint_pkg::TMR_INTEN];
  assign ev[vint_pkg::CH_LVD] = edge_ev[vint_pkg::SRC_LVD] & ~halt_reg;

  int_arb_if #(.NUM(vint_pkg::NUM_CHAN)) arb ();
  assign arb.pending = req_reg[5:0] & mask_reg[5:0];
  assign arb.first   = prio_reg[2:0];
  priority_pick #(.NUM(vint_pkg::NUM_CHAN)) u_pick (
    .arb (arb.arbiter)
  );

  // a halted core wakes only through a grant
  assign grant   = (state_reg == vint_pkg::ST_IDLE) & mask_reg[vint_pkg::MASK_GLOBAL] &
                   arb.hit & (i_core_ready | halt_reg);
  assign clr_vec = grant ? 6'(6'h01 << arb.chan) : 6'h00;

  // Bus decode
  assign wr_fire  = i_awvalid & i_wvalid & wr_ready_reg;
  assign wr_byte  = wr_fire & i_wstrb[0];
  assign wr_idx   = i_awaddr[11:2];
  assign rd_idx   = i_araddr[11:2];
  assign rd_fire  = i_arvalid & arready_reg;
  assign wr_req   = wr_byte & (wr_idx == vint_pkg::IDX_REQ);
  assign wr_mask  = wr_byte & (wr_idx == vint_pkg::IDX_MASK);
  assign wr_prio  = wr_byte & (wr_idx == vint_pkg::IDX_PRIO);
  assign wr_mode  = wr_byte & (wr_idx == vint_pkg::IDX_MODE);
  assign wr_emask = wr_byte & (wr_idx == vint_pkg::IDX_EMASK);
  assign wr_short = wr_byte & (wr_idx == vint_pkg::IDX_SHORT);
  assign wr_long  = wr_byte & (wr_idx == vint_pkg::IDX_LONG);
  assign rd_stat  = rd_fire & (rd_idx == vint_pkg::IDX_STAT);
  assign rd_val   = (rd_idx == vint_pkg::IDX_REQ)   ? req_reg   :
                    (rd_idx == vint_pkg::IDX_MASK)  ? mask_reg  :
                    (rd_idx == vint_pkg::IDX_PRIO)  ? prio_reg  :
                    (rd_idx == vint_pkg::IDX_MODE)  ? mode_reg  :
                    (rd_idx == vint_pkg::IDX_STAT)  ? stat_reg  :
                    (rd_idx == vint_pkg::IDX_EMASK) ? emask_reg :
                    (rd_idx == vint_pkg::IDX_SHORT) ? short_reg :
                    (rd_idx == vint_pkg::IDX_LONG)  ? long_reg  : 8'h00;

  // hold until vectored or written; new event wins
  assign req_next  = {wr_req ? i_wdata[7:6] : req_reg[7:6],
                      ((wr_req ? i_wdata[5:0] : req_reg[5:0]) & ~clr_vec) | ev};
  assign mask_next = {~grant & (wr_mask ? i_wdata[7] : mask_reg[7]),
                      wr_mask ? i_wdata[6:0] : mask_reg[6:0]};
  assign halt_next = ~grant & (halt_reg | i_halt);
  assign alt       = mode_reg[vint_pkg::MODE_ALT];
  assign stat_next = (rd_stat ? 8'h00 : stat_reg) | stat_set;

  always_comb begin
    short_next = wr_short ? i_wdata[7:0] : short_reg;
    long_next  = wr_long ? i_wdata[7:0] : long_reg;
    if (alt && i_short_tc) begin
      short_next[vint_pkg::TMR_EN] = 1'b0;
      long_next[vint_pkg::TMR_EN]  = 1'b1;
    end else if (alt && i_long_tc) begin
      long_next[vint_pkg::TMR_EN]  = 1'b0;
      short_next[vint_pkg::TMR_EN] = 1'b1;
    end
    short_next[vint_pkg::TMR_TOUT] = short_next[vint_pkg::TMR_TOUT] | i_short_tc;
    // timeout status on each terminal count
    long_next[vint_pkg::TMR_TOUT]  = long_next[vint_pkg::TMR_TOUT] | i_long_tc;
  end

  always_comb begin
    stat_set = 8'h00;
    stat_set[vint_pkg::ST_VECT]  = grant;
    stat_set[vint_pkg::ST_WAKE]  = grant & halt_reg;
    stat_set[vint_pkg::ST_SHORT] = i_short_tc;
    stat_set[vint_pkg::ST_LONG]  = i_long_tc;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_reg   <= vint_pkg::REQ_RST;
      mask_reg  <= vint_pkg::MASK_RST;
      prio_reg  <= vint_pkg::PRIO_RST;
      mode_reg  <= vint_pkg::MODE_RST;
      stat_reg  <= vint_pkg::STAT_RST;
      emask_reg <= vint_pkg::STAT_RST;
      short_reg <= vint_pkg::TCTRL_RST;
      long_reg  <= vint_pkg::TCTRL_RST;
      halt_reg  <= 1'b0;
      cpu_clk_en_reg <= 1'b1;
      int_out_reg    <= 1'b0;
    end else if (i_clk_en) begin
      req_reg   <= req_next;
      mask_reg  <= mask_next;
      prio_reg  <= wr_prio ? i_wdata[7:0] : prio_reg;
      mode_reg  <= wr_mode ? i_wdata[7:0] : mode_reg;
      emask_reg <= wr_emask ? i_wdata[7:0] : emask_reg;
      stat_reg  <= stat_next;
      short_reg <= short_next;
      long_reg  <= long_next;
      halt_reg  <= halt_next;
      cpu_clk_en_reg <= ~halt_next;
      int_out_reg    <= |(stat_next & (wr_emask ? i_wdata[7:0] : emask_reg));
    end
  end

  // Bus slave: address and data taken together, one of each at a time
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ready_reg <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= vint_pkg::RESP_OKAY;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= vint_pkg::RESP_OKAY;
      rdata_reg    <= 8'h00;
    end else if (i_clk_en) begin
      wr_ready_reg <= ~wr_ready_reg & ~bvalid_reg & i_awvalid & i_wvalid;
      arready_reg  <= ~arready_reg & ~rvalid_reg & i_arvalid;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= reg_known(wr_idx) ? vint_pkg::RESP_OKAY : vint_pkg::RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_val;
        rresp_reg  <= reg_known(rd_idx) ? vint_pkg::RESP_OKAY : vint_pkg::RESP_SLVERR;
      end else if (i_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // high byte then following low byte
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg    <= vint_pkg::ST_IDLE;
      chan_reg     <= 3'h0;
      hi_reg       <= 8'h00;
      ctx_save_reg <= 1'b0;
      pm_rd_reg    <= 1'b0;
      pm_addr_reg  <= 16'h0000;
      branch_reg   <= 1'b0;
      isr_addr_reg <= 16'h0000;
    end else if (i_clk_en) begin
      ctx_save_reg <= 1'b0;
      branch_reg   <= 1'b0;
      case (state_reg)
        vint_pkg::ST_IDLE: begin
          if (grant) begin
            state_reg    <= vint_pkg::ST_SAVE;
            chan_reg     <= arb.chan;
            ctx_save_reg <= 1'b1;
          end
        end
        vint_pkg::ST_SAVE: begin
          state_reg   <= vint_pkg::ST_FETCH_HI;
          pm_rd_reg   <= 1'b1;
          pm_addr_reg <= vec_addr(chan_reg);
        end
        vint_pkg::ST_FETCH_HI: begin
          state_reg   <= vint_pkg::ST_FETCH_LO;
          pm_addr_reg <= pm_addr_reg + 16'h0001;
        end
        vint_pkg::ST_FETCH_LO: begin
          state_reg <= vint_pkg::ST_BRANCH;
          pm_rd_reg <= 1'b0;
          hi_reg    <= i_pm_data;
        end
        vint_pkg::ST_BRANCH: begin
          state_reg    <= vint_pkg::ST_IDLE;
          branch_reg   <= 1'b1;
          isr_addr_reg <= {hi_reg, i_pm_data};
        end
        default: state_reg <= vint_pkg::ST_IDLE;
      endcase
    end
  end

  assign o_awready      = wr_ready_reg;
  assign o_wready       = wr_ready_reg;
  assign o_bvalid       = bvalid_reg;
  assign o_bresp        = bresp_reg;
  assign o_arready      = arready_reg;
  assign o_rvalid       = rvalid_reg;
  assign o_rresp        = rresp_reg;
  assign o_rdata        = {24'h000000, rdata_reg};
  assign o_short_enable = short_reg[vint_pkg::TMR_EN];
  assign o_long_enable  = long_reg[vint_pkg::TMR_EN];
  assign o_cpu_clk_en   = cpu_clk_en_reg;
  assign o_ctx_save     = ctx_save_reg;
  assign o_pm_rd        = pm_rd_reg;
  assign o_pm_addr      = pm_addr_reg;
  assign o_branch       = branch_reg;
  assign o_isr_addr     = isr_addr_reg;
  assign o_int_out      = int_out_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence fetch_lo_s;
    state_reg == vint_pkg::ST_FETCH_LO && i_clk_en;
  endsequence
  sequence branch_s;
    state_reg == vint_pkg::ST_BRANCH && i_clk_en;
  endsequence

  grant_disables_a: assert property (grant && i_clk_en |=>
    state_reg == vint_pkg::ST_SAVE && !mask_reg[vint_pkg::MASK_GLOBAL] && o_ctx_save)
    else $error("grant did not start vectoring");
  vector_fetch_a: assert property (fetch_lo_s ##1 branch_s |=>
    o_branch && o_isr_addr == {$past(i_pm_data, 2), $past(i_pm_data)})
    else $error("service address mismatch");
  vector_addr_a: assert property (state_reg == vint_pkg::ST_FETCH_HI |->
    o_pm_rd && o_pm_addr == {12'h000, chan_reg, 1'b0})
    else $error("wrong vector address");
  global_off_a: assert property (state_reg == vint_pkg::ST_IDLE &&
    !mask_reg[vint_pkg::MASK_GLOBAL] |=> state_reg == vint_pkg::ST_IDLE)
    else $error("vectoring while disabled");
  req_latch_a: assert property (|ev && i_clk_en |=>
    (req_reg[5:0] & $past(ev)) == $past(ev))
    else $error("event not latched");
  low_volt_halt_a: assert property (halt_reg && i_clk_en && !wr_req |=>
    $past(req_reg[vint_pkg::CH_LVD]) || !req_reg[vint_pkg::CH_LVD])
    else $error("low-voltage request during halt");
  halt_exit_a: assert property ($fell(halt_reg) |->
    state_reg == vint_pkg::ST_SAVE && o_cpu_clk_en)
    else $error("halt left without service");
  short_gate_a: assert property (ev[vint_pkg::CH_SHORT] |->
    short_reg[vint_pkg::TMR_INTEN])
    else $error("short timer request while disabled");
  long_status_a: assert property (i_long_tc && i_clk_en |=>
    long_reg[vint_pkg::TMR_TOUT])
    else $error("long timer status not set");
  alt_swap_a: assert property (alt && i_short_tc && i_clk_en && !wr_short && !wr_long |=>
    !o_short_enable && o_long_enable)
    else $error("alternating swap failed");
  req_clear_a: assert property (grant && i_clk_en && !ev[arb.chan] && !wr_req |=>
    !req_reg[chan_reg])
    else $error("vectored request not cleared");
endmodule : vectored_interrupt_unit
`default_nettype wire

// ### logic/vint_pkg.sv
`default_nettype none
package vint_pkg;
  localparam int NUM_CHAN    = 6;
  localparam int SYNC_STAGES = 2;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_MODE  = 10'h0f8;
  localparam logic [9:0] IDX_PRIO  = 10'h0f9;
  localparam logic [9:0] IDX_REQ   = 10'h0fa;
  localparam logic [9:0] IDX_MASK  = 10'h0fb;
  localparam logic [9:0] IDX_STAT  = 10'h0fc;
  localparam logic [9:0] IDX_EMASK = 10'h0fd;
  localparam logic [9:0] IDX_SHORT = 10'h0fe;
  localparam logic [9:0] IDX_LONG  = 10'h0ff;
  // Values after reset
  localparam logic [7:0] REQ_RST   = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] PRIO_RST  = 8'h00;
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] STAT_RST  = 8'h00;
  // Field positions
  localparam int MASK_GLOBAL = 7;
  localparam int EDGE_CHAN2  = 7;
  localparam int EDGE_CHAN0  = 6;
  localparam int TMR_EN      = 7;
  localparam int TMR_TOUT    = 5;
  localparam int TMR_INTEN   = 1;
  localparam int MODE_ALT    = 0;
  localparam int ST_VECT     = 0;
  localparam int ST_WAKE     = 1;
  localparam int ST_SHORT    = 2;
  localparam int ST_LONG     = 3;
  // Synchronised input sources
  localparam int SRC_LINE1 = 0;
  localparam int SRC_LINE2 = 1;
  localparam int SRC_LINE3 = 2;
  localparam int SRC_CMP1  = 3;
  localparam int SRC_CMP2  = 4;
  localparam int SRC_LVD   = 5;
  // Channel numbers
  localparam int CH_ZERO  = 0;
  localparam int CH_ONE   = 1;
  localparam int CH_TWO   = 2;
  localparam int CH_LONG  = 3;
  localparam int CH_SHORT = 4;
  localparam int CH_LVD   = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_SAVE, ST_FETCH_HI, ST_FETCH_LO, ST_BRANCH} vect_state_t;
endpackage : vint_pkg
`default_nettype wire
